// ---- shared/playback_consts.svh ----
// constants for the playback command and data transfer link
`ifndef PLAYBACK_CONSTS_SVH
`define PLAYBACK_CONSTS_SVH

// ==========================================
// command and status words
`define CMD_RATE_PREFIX 12'h523
`define CMD_POLL_SYNC 16'h5202
`define CMD_PLAY_FIRST 16'h2C00
`define CMD_PLAY_SECOND 16'h2000
`define CMD_PLAY_THIRD_PREFIX 8'h20
`define CMD_IDLE 16'h0000
`define CMD_STOP_PLAY 16'h5220

// ==========================================
// rate codes and frame sizes in words
`define RATE_8K5 4'h0
`define RATE_6K3 4'h1
`define RATE_5K3 4'h2
`define RATE_4K8 4'h3
`define RATE_4K1 4'h4
`define FSIZE_8K5 8'h10
`define FSIZE_6K3 8'h0C
`define FSIZE_5K3 8'h0A
`define FSIZE_4K8 8'h09
`define FSIZE_4K1 8'h08
`define TX_BUF_WORDS 5'h10

// ==========================================
// frame type field, bits 1-0 of first word
`define FTYPE_6K3 2'h0
`define FTYPE_5K3 2'h1
`define FTYPE_CNG 2'h2
`define FTYPE_CNG_REPEAT 2'h3

// ==========================================
// transfer path select values
`define PATH_REGS 2'h0
`define PATH_ALIGNED 2'h1
`define PATH_TXBUF 2'h3

// ==========================================
// timing
`define FRAME_TIME_US 30000
`define CLK_PERIOD_NS 40
`define FRAME_CYCLES ((`FRAME_TIME_US * 1000) / `CLK_PERIOD_NS)
`define SYNC_FRAMES 2'h2

`endif

// ---- shared/playback_link_if.sv ----
// link between host processor and playback device
`timescale 1ns/1ns
`include "playback_consts.svh"

interface playback_link_if;
  logic ctrl_wr;
  logic [15:0] ctrl_data;
  logic stat_rd;
  logic [15:0] stat_data;
  logic command_accept_ready;
  logic response_pending;
  logic data_phase_flag_n;
  logic tx_wr;
  logic [15:0] tx_data;
  logic tx_buffer_ready;

  modport device (
    input ctrl_wr,
    input ctrl_data,
    input stat_rd,
    output stat_data,
    output command_accept_ready,
    output response_pending,
    output data_phase_flag_n,
    input tx_wr,
    input tx_data,
    output tx_buffer_ready
  );

  modport host (
    output ctrl_wr,
    output ctrl_data,
    output stat_rd,
    input stat_data,
    input command_accept_ready,
    input response_pending,
    input data_phase_flag_n,
    output tx_wr,
    output tx_data,
    input tx_buffer_ready
  );
endinterface : playback_link_if

// ---- shared/playback_pkg.sv ----
// types and shared decode for the playback link
`include "playback_consts.svh"

package playback_pkg;

  // ==========================================
  // state types
  typedef enum logic [2:0] {
    DEV_IDLE,
    DEV_SYNC,
    DEV_WAIT_SECOND,
    DEV_WAIT_THIRD,
    DEV_DATA
  } dev_state_t;

  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_ISSUE,
    HOST_AWAIT
  } host_state_t;

  typedef enum logic [2:0] {
    STEP_RATE,
    STEP_SYNC,
    STEP_FIRST,
    STEP_SECOND,
    STEP_THIRD,
    STEP_WORD,
    STEP_STOP
  } host_step_t;

  // ==========================================
  // rate code to frame size, reserved codes give zero
  function automatic logic [7:0] frame_size(input logic [3:0] rate);
    logic [7:0] size;
    size = 8'h00;
    if (rate == `RATE_8K5) begin
      size = `FSIZE_8K5;
    end else if (rate == `RATE_6K3) begin
      size = `FSIZE_6K3;
    end else if (rate == `RATE_5K3) begin
      size = `FSIZE_5K3;
    end else if (rate == `RATE_4K8) begin
      size = `FSIZE_4K8;
    end else if (rate == `RATE_4K1) begin
      size = `FSIZE_4K1;
    end
    return size;
  endfunction : frame_size

endpackage : playback_pkg

// ---- tb/playback_host_transfer_tb.sv ----
// self-checking bench for both ends of the playback link
`timescale 1ns/1ns

module playback_host_transfer_tb;
  localparam int FRAME_CYCLES = 400;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  logic stop_i = 1'b0;
  logic [3:0] rate_i = 4'h0;
  logic [15:0] src_word_i = 16'hA000;
  logic src_valid_i = 1'b1;
  logic [15:0] tx_word_i = 16'h0000;
  logic tx_valid_i = 1'b0;
  logic [1:0] path = 2'h0;
  logic src_ready_o, tx_ready_o, busy_o, play_tick_o, play_type_valid_o;
  logic [15:0] last_status_o, play_word_o;
  logic [3:0] rate_o;
  logic [1:0] play_type_o;
  logic [15:0] expw = 16'hA000;
  logic [7:0] fsz [16] = '{0: 8'h10, 1: 8'h0C, 2: 8'h0A, 3: 8'h09, 4: 8'h08, default: 8'h00};
  logic [15:0] seen[$];
  int bad_count = 0;
  int check_count = 0;
  int taken = 0;
  int ticks = 0;
  logic src_took = 1'b0;
  logic tx_took = 1'b0;

  playback_link_if link ();
  playback_device #(.FRAME_CYCLES(FRAME_CYCLES)) playback_device_inst (.clock_i(clock_i), .rst_i(rst_i),
    .link(link), .transfer_path_select_i(path), .rate_o(rate_o), .playing_o(), .play_tick_o(play_tick_o),
    .play_word_o(play_word_o), .play_type_o(play_type_o), .play_type_valid_o(play_type_valid_o));
  playback_host playback_host_inst (.clock_i(clock_i), .rst_i(rst_i), .link(link), .start_i(start_i),
    .stop_i(stop_i), .rate_i(rate_i), .src_word_i(src_word_i), .src_valid_i(src_valid_i),
    .src_ready_o(src_ready_o), .tx_word_i(tx_word_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .busy_o(busy_o), .last_status_o(last_status_o));
  playback_link_chk #(.FRAME_CYCLES(FRAME_CYCLES)) playback_link_chk_inst (.clock_i(clock_i), .rst_i(rst_i),
    .ctrl_wr(link.ctrl_wr), .ctrl_data(link.ctrl_data), .stat_rd(link.stat_rd), .stat_data(link.stat_data),
    .command_accept_ready(link.command_accept_ready), .response_pending(link.response_pending),
    .data_phase_flag_n(link.data_phase_flag_n), .tx_wr(link.tx_wr), .tx_buffer_ready(link.tx_buffer_ready));

  initial begin
    forever #20 clock_i = ~clock_i;
  end

  // ==========================================
  // comparison and closing
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================
  // sources, status trail and playout watch
  always @(negedge clock_i) begin
    if (src_took) src_word_i <= src_word_i + 16'h0001;
    if (tx_took) tx_word_i <= tx_word_i + 16'h0001;
  end

  always @(posedge clock_i) begin
    src_took <= (src_ready_o === 1'b1) && src_valid_i;
    tx_took <= (link.tx_wr === 1'b1);
    if (link.tx_wr === 1'b1) begin
      taken <= taken + 1;
    end
    if (link.stat_rd === 1'b1 && link.response_pending === 1'b1) seen.push_back(link.stat_data);
    if (play_tick_o === 1'b1) begin
      ticks <= ticks + 1;
      check(16'(play_type_valid_o), 16'(rate_i == 4'h1 || rate_i == 4'h2));
      check(16'(play_type_o), 16'(play_word_o[1:0]));
    end
  end

  // ==========================================
  // one playback session
  task automatic run(input logic [3:0] rate, input logic [1:0] sel, input bit stall);
    int i;
    int g;
    int grants;
    seen.delete();
    taken = 0;
    ticks = 0;
    grants = 0;
    rate_i = rate;
    path = sel;
    src_valid_i = !stall;
    tx_valid_i = stall;
    start_i = 1'b1;
    @(negedge clock_i);
    start_i = 1'b0;
    if (stall) begin
      i = 0;
      g = 0;
      while (g < 40 && i < 4000) begin
        @(negedge clock_i);
        g = (tx_ready_o === 1'b0 && taken > 0) ? g + 1 : 0;
        i++;
      end
      check(16'(i < 4000), 16'h0001);
      if (sel == 2'h3) check(16'(taken), 16'(16 * (9 + ticks)));
      else check(16'(taken == 16 || taken == 32), 16'h0001);
      tx_valid_i = 1'b0;
      src_valid_i = 1'b1;
    end
    repeat (1500) @(negedge clock_i);
    stop_i = 1'b1;
    @(negedge clock_i);
    stop_i = 1'b0;
    i = 0;
    while (busy_o !== 1'b0 && i < 3000) begin
      @(negedge clock_i);
      i++;
    end
    check(16'(busy_o), 16'h0000);
    check(16'(rate_o), 16'(rate));
    check(16'(link.data_phase_flag_n), 16'h0001);
    check(last_status_o, 16'h5220);
    check(seen[0], {12'h523, rate});
    check(seen[1], 16'h5202);
    check(seen[2], 16'h2C00);
    i = 3;
    while (i + 1 < seen.size()) begin
      check(seen[i], 16'h2000);
      g = int'(seen[i + 1][7:0]);
      check(seen[i + 1], (g == 0) ? 16'h2000 : {8'h20, fsz[rate]});
      for (int j = 0; j < g; j++) begin
        check(seen[i + 2 + j], expw);
        expw = expw + 16'h0001;
      end
      grants += (g != 0) ? 1 : 0;
      i += 2 + g;
    end
    check(seen[seen.size() - 1], 16'h5220);
    check(16'(grants != 0), 16'(!stall && fsz[rate] != 8'h00));
    $display("run rate %0d path %0d done", rate, sel);
  endtask : run

  // ==========================================
  // main sequence
  initial begin
    repeat (6) @(negedge clock_i);
    rst_i = 1'b0;
    check(16'(link.data_phase_flag_n), 16'h0001);
    check(16'(link.command_accept_ready), 16'h0001);
    check(16'(tx_ready_o), 16'h0000);
    $display("reset test done");
    for (int r = 0; r < 6; r++) begin
      run(r[3:0], 2'h0, 1'b0);
    end
    run(4'h0, 2'h3, 1'b1);
    run(4'h0, 2'h1, 1'b1);
    report_and_stop();
  end

  initial begin
    repeat (40000) @(posedge clock_i);
    bad_count++;
    report_and_stop();
  end
endmodule : playback_host_transfer_tb

// ---- tb/playback_link_chk.sv ----
// concurrent checks on the playback command, status and data link
`timescale 1ns/1ns

module playback_link_chk #(
  parameter int FRAME_CYCLES = 400
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ctrl_wr,
  input wire logic [15:0] ctrl_data,
  input wire logic stat_rd,
  input wire logic [15:0] stat_data,
  input wire logic command_accept_ready,
  input wire logic response_pending,
  input wire logic data_phase_flag_n,
  input wire logic tx_wr,
  input wire logic tx_buffer_ready
);
  localparam int SYNC_MAX = 2 * FRAME_CYCLES + 4;
  logic take;
  logic flag_q_ff;
  logic [7:0] grant_ff;
  logic [7:0] words_ff;

  assign take = ctrl_wr && command_accept_ready;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // ==========================================
  // granted word counting
  always_ff @(posedge clock_i) begin
    flag_q_ff <= rst_i | data_phase_flag_n;
    if (flag_q_ff && !data_phase_flag_n) begin
      grant_ff <= stat_data[7:0];
      words_ff <= 8'h00;
    end else if (!data_phase_flag_n && take) begin
      words_ff <= words_ff + 8'h01;
    end
  end

  // ==========================================
  // assertions
  a_write_needs_ready: assert property (ctrl_wr |-> command_accept_ready)
    else $error("control write while not ready");
  a_pending_blocks_ready: assert property (response_pending |-> !command_accept_ready)
    else $error("ready high while status pending");
  a_pending_holds: assert property (response_pending && !stat_rd |=> response_pending)
    else $error("pending dropped without read");
  a_read_clears: assert property (stat_rd && response_pending |=> !response_pending)
    else $error("status read left pending set");
  a_rate_echo: assert property (take && ctrl_data[15:4] == 12'h523 |=>
    response_pending && stat_data == $past(ctrl_data))
    else $error("rate command not echoed");
  a_sync_echo: assert property (take && ctrl_data == 16'h5202 |=> response_pending && stat_data == 16'h5202)
    else $error("poll sync not answered");
  a_second_echo: assert property (take && ctrl_data == 16'h2000 |=> stat_data == 16'h2000)
    else $error("second command not answered");
  a_first_sync: assert property (take && ctrl_data == 16'h2C00 && data_phase_flag_n |=>
    (!response_pending)[*8] ##[1:SYNC_MAX] (response_pending && stat_data == 16'h2C00))
    else $error("first command answer timing wrong");
  a_grant_flag: assert property ($fell(data_phase_flag_n) |->
    $rose(response_pending) && stat_data[15:8] == 8'h20 && stat_data[7:0] != 8'h00)
    else $error("data flag fell without grant");
  a_flag_end: assert property ($rose(data_phase_flag_n) |-> words_ff == grant_ff)
    else $error("data flag released at wrong word");
  a_flag_reset: assert property ($fell(rst_i) |-> data_phase_flag_n)
    else $error("data flag low after reset");
  a_tx_needs_ready: assert property (tx_wr |-> tx_buffer_ready)
    else $error("buffer write while not ready");

  c_grant: cover property ($fell(data_phase_flag_n));
  c_sync_post: cover property ($rose(response_pending) && stat_data == 16'h2C00);
  c_buffer_full: cover property ($fell(tx_buffer_ready));
endmodule : playback_link_chk

// ---- verilog/playback_device.sv ----
// playback device end: command interpreter, frame queue and transmit buffer
`timescale 1ns/1ns
`include "playback_consts.svh"

module playback_device #(
  parameter int FRAME_CYCLES = `FRAME_CYCLES,
  parameter int QUEUE_FRAMES = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  playback_link_if.device link,
  input wire logic [1:0] transfer_path_select_i,
  output logic [3:0] rate_o,
  output logic playing_o,
  output logic play_tick_o,
  output logic [15:0] play_word_o,
  output logic [1:0] play_type_o,
  output logic play_type_valid_o
);

  localparam int CW = $clog2(FRAME_CYCLES + 1);
  localparam int QW = $clog2(QUEUE_FRAMES + 1);
  localparam int PW = (QUEUE_FRAMES > 1) ? $clog2(QUEUE_FRAMES) : 1;

  // ==========================================
  // declarations
  playback_pkg::dev_state_t state_ff;
  playback_pkg::dev_state_t nxt_state;
  logic [3:0] rate_ff;
  logic [15:0] resp_ff;
  logic pending_ff;
  logic flag_n_ff;
  logic [CW-1:0] frame_cnt_ff;
  logic frame_tick;
  logic [1:0] sync_cnt_ff;
  logic [7:0] grant_ff;
  logic [7:0] word_idx_ff;
  logic [15:0] reg_first_ff;
  logic [15:0] first_mem [QUEUE_FRAMES];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [QW-1:0] count_ff;
  logic [4:0] tx_cnt_ff;
  logic [15:0] tx_first_ff;
  logic accept;
  logic post;
  logic [15:0] post_data;
  logic flush;
  logic last_word;
  logic commit_reg;
  logic tx_move;
  logic commit;
  logic [15:0] commit_word;
  logic consume;
  logic queue_full;
  logic tx_full;
  logic tx_path;
  logic [7:0] fsize;
  logic [7:0] grant_calc;
  logic [15:0] cmd;

  assign cmd = link.ctrl_data;
  assign fsize = playback_pkg::frame_size(rate_ff);
  assign queue_full = (count_ff == QW'(QUEUE_FRAMES));
  assign accept = link.ctrl_wr && link.command_accept_ready;
  assign last_word = (word_idx_ff + 8'h01) == grant_ff;
  assign commit_reg = accept && (state_ff == playback_pkg::DEV_DATA) && last_word;
  assign tx_path = (transfer_path_select_i == `PATH_TXBUF) || (transfer_path_select_i == `PATH_ALIGNED);
  // full at frame size, never beyond one 16-word sub-block
  assign tx_full = (tx_cnt_ff != 5'h00) &&
                   (({3'h0, tx_cnt_ff} >= fsize) || (tx_cnt_ff == `TX_BUF_WORDS));
  // buffer empties into queue at once, or only on a frame boundary when aligned
  assign tx_move = tx_path && tx_full && !queue_full &&
                   ((transfer_path_select_i == `PATH_TXBUF) || frame_tick);
  assign commit = commit_reg || tx_move;
  assign commit_word = commit_reg ? ((word_idx_ff == 8'h00) ? cmd : reg_first_ff) : tx_first_ff;
  assign consume = frame_tick && (count_ff != QW'(0)) && playing_o;

  // ==========================================
  // link outputs
  assign link.stat_data = resp_ff;
  assign link.response_pending = pending_ff;
  assign link.command_accept_ready = !pending_ff && (state_ff != playback_pkg::DEV_SYNC);
  assign link.data_phase_flag_n = flag_n_ff;
  assign link.tx_buffer_ready = tx_path && playing_o && !tx_full;
  assign rate_o = rate_ff;

  // ==========================================
  // frame period timer
  always_ff @(posedge clock_i) begin
    if (rst_i || frame_tick) begin
      frame_cnt_ff <= '0;
    end else begin
      frame_cnt_ff <= frame_cnt_ff + CW'(1);
    end
  end
  assign frame_tick = (frame_cnt_ff == CW'(FRAME_CYCLES - 1));

  // ==========================================
  // command decode
  always_comb begin
    nxt_state = state_ff;
    post = 1'b0;
    post_data = cmd;
    flush = 1'b0;
    grant_calc = 8'h00;
    // buffer paths move no data words through the registers
    if (!queue_full && !tx_path) begin
      grant_calc = (cmd[7:0] < fsize) ? cmd[7:0] : fsize;
    end
    case (state_ff)
      playback_pkg::DEV_SYNC: begin
        if (frame_tick && (sync_cnt_ff == `SYNC_FRAMES - 2'h1)) begin
          post = 1'b1;
          post_data = `CMD_PLAY_FIRST;
          nxt_state = playback_pkg::DEV_WAIT_SECOND;
        end
      end
      playback_pkg::DEV_DATA: begin
        if (accept) begin
          post = 1'b1;
          if (last_word) begin
            nxt_state = playback_pkg::DEV_WAIT_SECOND;
          end
        end
      end
      default: begin
        if (accept) begin
          post = 1'b1;
          if ((cmd == `CMD_IDLE) || (cmd == `CMD_STOP_PLAY)) begin
            flush = 1'b1;
            nxt_state = playback_pkg::DEV_IDLE;
          end else if ((state_ff == playback_pkg::DEV_IDLE) && (cmd == `CMD_PLAY_FIRST)) begin
            post = 1'b0;
            nxt_state = playback_pkg::DEV_SYNC;
          end else if ((state_ff == playback_pkg::DEV_WAIT_SECOND) && (cmd == `CMD_PLAY_SECOND)) begin
            nxt_state = playback_pkg::DEV_WAIT_THIRD;
          end else if ((state_ff == playback_pkg::DEV_WAIT_THIRD) && (cmd[15:8] == `CMD_PLAY_THIRD_PREFIX)) begin
            post_data = {`CMD_PLAY_THIRD_PREFIX, grant_calc};
            nxt_state = (grant_calc == 8'h00) ? playback_pkg::DEV_WAIT_SECOND : playback_pkg::DEV_DATA;
          end
        end
      end
    endcase
  end

  // ==========================================
  // state, sync and rate
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_ff <= playback_pkg::DEV_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i || (state_ff != playback_pkg::DEV_SYNC)) begin
      sync_cnt_ff <= 2'h0;
    end else if (frame_tick) begin
      sync_cnt_ff <= sync_cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rate_ff <= `RATE_8K5;
    end else if (accept && (state_ff != playback_pkg::DEV_DATA) && (cmd[15:4] == `CMD_RATE_PREFIX)) begin
      rate_ff <= cmd[3:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      playing_o <= 1'b0;
    end else begin
      playing_o <= (nxt_state != playback_pkg::DEV_IDLE);
    end
  end

  // ==========================================
  // response register and pending flag, posting wins over a read
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      resp_ff <= 16'h0000;
    end else if (post) begin
      resp_ff <= post_data;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pending_ff <= 1'b0;
    end else if (post) begin
      pending_ff <= 1'b1;
    end else if (link.stat_rd) begin
      pending_ff <= 1'b0;
    end
  end

  // ==========================================
  // data phase: grant, word index, flag
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      grant_ff <= 8'h00;
      word_idx_ff <= 8'h00;
      reg_first_ff <= 16'h0000;
    end else if (nxt_state == playback_pkg::DEV_DATA && state_ff == playback_pkg::DEV_WAIT_THIRD) begin
      grant_ff <= grant_calc;
      word_idx_ff <= 8'h00;
    end else if (accept && (state_ff == playback_pkg::DEV_DATA)) begin
      word_idx_ff <= word_idx_ff + 8'h01;
      if (word_idx_ff == 8'h00) begin
        reg_first_ff <= cmd;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      flag_n_ff <= 1'b1;
    end else begin
      flag_n_ff <= (nxt_state != playback_pkg::DEV_DATA);
    end
  end

  // ==========================================
  // transmit buffer fill
  always_ff @(posedge clock_i) begin
    if (rst_i || flush || tx_move) begin
      tx_cnt_ff <= 5'h00;
    end else if (link.tx_wr && link.tx_buffer_ready) begin
      tx_cnt_ff <= tx_cnt_ff + 5'h01;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tx_first_ff <= 16'h0000;
    end else if (link.tx_wr && link.tx_buffer_ready && (tx_cnt_ff == 5'h00)) begin
      tx_first_ff <= link.tx_data;
    end
  end

  // ==========================================
  // frame queue, one entry per frame
  always_ff @(posedge clock_i) begin
    if (commit) begin
      first_mem[wr_ptr_ff] <= commit_word;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i || flush) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (commit) begin
        wr_ptr_ff <= (wr_ptr_ff == PW'(QUEUE_FRAMES - 1)) ? '0 : wr_ptr_ff + PW'(1);
      end
      if (consume) begin
        rd_ptr_ff <= (rd_ptr_ff == PW'(QUEUE_FRAMES - 1)) ? '0 : rd_ptr_ff + PW'(1);
      end
      count_ff <= count_ff + QW'(commit) - QW'(consume);
    end
  end

  // ==========================================
  // frame playout and type decode
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      play_tick_o <= 1'b0;
      play_word_o <= 16'h0000;
      play_type_o <= `FTYPE_6K3;
      play_type_valid_o <= 1'b0;
    end else begin
      play_tick_o <= consume;
      if (consume) begin
        play_word_o <= first_mem[rd_ptr_ff];
        play_type_o <= first_mem[rd_ptr_ff][1:0];
        play_type_valid_o <= (rate_ff == `RATE_6K3) || (rate_ff == `RATE_5K3);
      end
    end
  end

endmodule : playback_device

// ---- verilog/playback_host.sv ----
// playback host end: drives the command, status and data word handshake
`timescale 1ns/1ns
`include "playback_consts.svh"

module playback_host (
  input wire logic clock_i,
  input wire logic rst_i,
  playback_link_if.host link,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic [3:0] rate_i,
  input wire logic [15:0] src_word_i,
  input wire logic src_valid_i,
  output logic src_ready_o,
  input wire logic [15:0] tx_word_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic busy_o,
  output logic [15:0] last_status_o
);

  // ==========================================
  // declarations
  playback_pkg::host_state_t state_ff;
  playback_pkg::host_step_t step_ff;
  logic [3:0] rate_ff;
  logic [7:0] left_ff;
  logic stop_req_ff;
  logic issue;
  logic take;
  logic [15:0] cmd_word;

  // ==========================================
  // command words for each step
  always_comb begin
    cmd_word = `CMD_STOP_PLAY;
    case (step_ff)
      playback_pkg::STEP_RATE: cmd_word = {`CMD_RATE_PREFIX, rate_ff};
      playback_pkg::STEP_SYNC: cmd_word = `CMD_POLL_SYNC;
      playback_pkg::STEP_FIRST: cmd_word = `CMD_PLAY_FIRST;
      playback_pkg::STEP_SECOND: cmd_word = `CMD_PLAY_SECOND;
      playback_pkg::STEP_THIRD: cmd_word = {`CMD_PLAY_THIRD_PREFIX, playback_pkg::frame_size(rate_ff)};
      playback_pkg::STEP_WORD: cmd_word = src_word_i;
      default: cmd_word = `CMD_STOP_PLAY;
    endcase
  end

  // write only when the device takes commands
  assign issue = (state_ff == playback_pkg::HOST_ISSUE) && link.command_accept_ready &&
                 ((step_ff != playback_pkg::STEP_WORD) || src_valid_i);
  assign take = (state_ff == playback_pkg::HOST_AWAIT) && link.response_pending;
  assign link.ctrl_wr = issue;
  assign link.ctrl_data = cmd_word;
  assign link.stat_rd = take;
  assign src_ready_o = issue && (step_ff == playback_pkg::STEP_WORD);
  // buffer path checks ready on every word
  assign link.tx_wr = tx_valid_i && link.tx_buffer_ready;
  assign link.tx_data = tx_word_i;
  assign tx_ready_o = link.tx_buffer_ready;
  assign busy_o = (state_ff != playback_pkg::HOST_IDLE);

  // ==========================================
  // stop request held until the host returns to idle, acted on at the next cycle boundary
  always_ff @(posedge clock_i) begin
    if (rst_i || (state_ff == playback_pkg::HOST_IDLE)) begin
      stop_req_ff <= 1'b0;
    end else if (stop_i) begin
      stop_req_ff <= 1'b1;
    end
  end

  // ==========================================
  // sequencer
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_ff <= playback_pkg::HOST_IDLE;
      step_ff <= playback_pkg::STEP_RATE;
      rate_ff <= `RATE_8K5;
      left_ff <= 8'h00;
    end else begin
      case (state_ff)
        playback_pkg::HOST_IDLE: begin
          if (start_i) begin
            rate_ff <= rate_i;
            step_ff <= playback_pkg::STEP_RATE;
            state_ff <= playback_pkg::HOST_ISSUE;
          end
        end
        playback_pkg::HOST_ISSUE: begin
          if (issue) begin
            state_ff <= playback_pkg::HOST_AWAIT;
          end
        end
        default: begin
          if (take) begin
            state_ff <= playback_pkg::HOST_ISSUE;
            case (step_ff)
              playback_pkg::STEP_RATE: step_ff <= playback_pkg::STEP_SYNC;
              playback_pkg::STEP_SYNC: step_ff <= playback_pkg::STEP_FIRST;
              playback_pkg::STEP_FIRST: step_ff <= stop_req_ff ? playback_pkg::STEP_STOP : playback_pkg::STEP_SECOND;
              playback_pkg::STEP_SECOND: step_ff <= playback_pkg::STEP_THIRD;
              playback_pkg::STEP_THIRD: begin
                left_ff <= link.stat_data[7:0];
                if (link.stat_data[7:0] == 8'h00) begin
                  step_ff <= stop_req_ff ? playback_pkg::STEP_STOP : playback_pkg::STEP_SECOND;
                end else begin
                  step_ff <= playback_pkg::STEP_WORD;
                end
              end
              playback_pkg::STEP_WORD: begin
                left_ff <= left_ff - 8'h01;
                if (left_ff == 8'h01) begin
                  step_ff <= stop_req_ff ? playback_pkg::STEP_STOP : playback_pkg::STEP_SECOND;
                end
              end
              default: state_ff <= playback_pkg::HOST_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      last_status_o <= 16'h0000;
    end else if (take) begin
      last_status_o <= link.stat_data;
    end
  end

endmodule : playback_host
